// [design/cpe_pkg.sv]
// constants and types for the cam profile evaluator
package cpe_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_STROKE = 8'h04;
	localparam logic [7:0]  A_CYCLE  = 8'h08;
	localparam logic [7:0]  A_STD    = 8'h0C;
	localparam logic [7:0]  A_STAT   = 8'h10;
	localparam logic [7:0]  A_FEED   = 8'h14;
	localparam logic [7:0]  A_POS    = 8'h18;
	localparam logic [7:0]  A_ASTRK  = 8'h1C;
	localparam logic [7:0]  A_PROF   = 8'h20;
	// ------------------------------------------------------------
	// profile word fields and reset values
	// ------------------------------------------------------------
	localparam int          F_TYPE   = 0;
	localparam int          F_RES    = 2;
	localparam int          F_START  = 4;
	localparam int          F_NPT    = 16;
	localparam logic [26:0] PROF_RST  = 27'h0020001;
	localparam logic [31:0] CYCLE_RST = 32'h0000_2710;
	// ------------------------------------------------------------
	// encodings and limits
	// ------------------------------------------------------------
	localparam logic [1:0]  TYPE_RATIO = 2'h1;
	localparam logic [1:0]  TYPE_COORD = 2'h2;
	localparam logic [3:0]  CAM_MAX    = 4'h8;
	localparam logic [11:0] RES_BASE   = 12'h100;
	localparam logic [10:0] NPT_MIN    = 11'h002;
	localparam logic [10:0] NPT_MAX    = 11'h400;
	localparam logic signed [31:0] RATIO_FULL = 32'sh0001_86A0;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00000,
		S_EVAL = 5'b00001,
		S_RD   = 5'b00010,
		S_DLD  = 5'b00011,
		S_DIV  = 5'b00100,
		S_DFIX = 5'b00101,
		S_R1   = 5'b00110,
		S_R2   = 5'b00111,
		S_R3   = 5'b01000,
		S_R4   = 5'b01001,
		S_R5   = 5'b01010,
		S_R6   = 5'b01011,
		S_C1   = 5'b01100,
		S_C2   = 5'b01101,
		S_C3   = 5'b01110,
		S_C4   = 5'b01111,
		S_C5   = 5'b10000,
		S_C6   = 5'b10001,
		S_FIN  = 5'b10010
	} cpe_state_t;

	typedef enum logic [1:0] {
		PH_WL  = 2'b00,
		PH_W0  = 2'b01,
		PH_POS = 2'b10
	} cpe_phase_t;
endpackage

// [design/cpe_top.sv]
// cam profile evaluator with ahb-lite register slave
// Overview of operation
// - cam zero is linear, 100% at end
// - cams one to eight are user profiles
// - type 1 stroke ratio, 2 coordinates
// - resolution only 256, 512, 1024, 2048
// - ratio entries signed, three decimal places
// - feed is standard plus stroke times ratio
// - interpolate linearly between neighbouring table points
// - wrap adds stroke times last ratio, a backward wrap subtracts it
// - start index maps position zero to entry
// - start index per profile, below resolution
// - ratio: cam and stroke latched on engage
// - ratio: standard updates at index zero point
// - coordinate profiles hold 2 to 1024 points
// - extrapolate from nearest two points at ends
// - coordinate feed is standard plus output
// - coordinate wrap adds out(L) minus out(0), a backward wrap subtracts it
// - coordinate profiles ignore start index
// - coordinate: only cam latched on engage
// - stroke amount equals 100% ratio displacement
`timescale 1ns/1ps
module cpe_top (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic      [31:0]        hrdata,
	output logic                    hresp,
	input  wire logic               step_valid,
	input  wire logic signed [31:0] step_delta,
	output logic                    step_ready,
	output logic      [14:0]        tbl_addr,
	input  wire logic [31:0]        tbl_rdata,
	output logic      [31:0]        feed_pos,
	output logic                    feed_valid
);
	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic        ap_wr;
	logic        ap_hit;
	logic        rd_pend;
	logic [7:0]  ap_addr;
	logic [31:0] rd_val;
	logic        wr;
	logic        take;

	assign take = hsel && hready && htrans[1];
	assign wr   = ap_wr && ap_hit;

	// reads take one wait state so a preceding write is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr     <= 1'b0;
			ap_hit    <= 1'b0;
			rd_pend   <= 1'b0;
			ap_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			ap_wr     <= take && hwrite;
			rd_pend   <= take && !hwrite;
			hreadyout <= !(take && !hwrite);
			hresp     <= 1'b0;
			if (take) begin
				ap_addr <= haddr[7:0];
				ap_hit  <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
			end
			if (rd_pend) begin
				hrdata <= ap_hit ? rd_val : 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic               cam_engage_command;
	logic [3:0]         cam_req;
	logic signed [31:0] stroke_req;
	logic [31:0]        cyc_len;
	logic [26:0]        prof [0:7];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cam_engage_command <= 1'b0;
			cam_req    <= 4'h0;
			stroke_req <= 32'sh0000_0000;
			cyc_len    <= cpe_pkg::CYCLE_RST;
		end else if (wr) begin
			if (ap_addr == cpe_pkg::A_CTRL) begin
				cam_engage_command <= hwdata[0];
				cam_req <= hwdata[7:4];
			end
			if (ap_addr == cpe_pkg::A_STROKE) begin
				stroke_req <= hwdata;
			end
			// a zero cycle would make the divider divide by zero
			if (ap_addr == cpe_pkg::A_CYCLE && hwdata != 32'h0000_0000) begin
				cyc_len <= hwdata;
			end
		end
	end

	generate
		for (genvar g = 0; g < 8; g++) begin : g_prof
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					prof[g] <= cpe_pkg::PROF_RST;
				end else if (wr && ap_addr == cpe_pkg::A_PROF + 8'(4 * g)) begin
					prof[g] <= hwdata[26:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// evaluator state
	// ------------------------------------------------------------
	cpe_pkg::cpe_state_t state;
	cpe_pkg::cpe_state_t rret;
	cpe_pkg::cpe_state_t dret;
	cpe_pkg::cpe_phase_t phase;
	logic               engage_q;
	logic               pend;
	logic               rd_ph;
	logic               wrap_dn;
	logic [3:0]         cam;
	logic [1:0]         ctype;
	logic [11:0]        res;
	logic [10:0]        sidx;
	logic [10:0]        npt;
	logic [10:0]        k;
	logic signed [31:0] stroke;
	logic signed [31:0] std;
	logic [31:0]        cyc_pos;
	logic signed [32:0] q;
	logic [31:0]        rdat;
	logic [12:0]        jr;
	logic [31:0]        rm;
	logic signed [31:0] ra;
	logic signed [31:0] rb;
	logic signed [31:0] xa;
	logic signed [31:0] xb;
	logic signed [31:0] ya;
	logic signed [31:0] yb;
	logic signed [63:0] ev;
	logic signed [63:0] acc;
	logic signed [63:0] dv_num;
	logic signed [63:0] dv_quo;
	logic [31:0]        dv_den;
	logic [32:0]        dv_rem;
	logic [32:0]        dv_try;
	logic [5:0]         dv_cnt;
	logic               dv_neg;

	// ------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------
	logic [26:0]        preq;
	logic [11:0]        res_req;
	logic [10:0]        npt_req;
	logic signed [33:0] np;
	logic               wrap_up;
	logic               wrap_lo;
	logic [31:0]        pos_new;
	logic [2:0]         cbase;
	logic [12:0]        jb;

	assign preq    = prof[3'(cam_req - 4'h1)];
	assign res_req = 12'(cpe_pkg::RES_BASE << preq[cpe_pkg::F_RES +: 2]);
	assign npt_req = (preq[cpe_pkg::F_NPT +: 11] < cpe_pkg::NPT_MIN) ? cpe_pkg::NPT_MIN :
		(preq[cpe_pkg::F_NPT +: 11] > cpe_pkg::NPT_MAX) ? cpe_pkg::NPT_MAX :
		preq[cpe_pkg::F_NPT +: 11];
	assign np      = $signed({2'b00, cyc_pos}) + 34'(step_delta);
	assign wrap_up = np >= $signed({2'b00, cyc_len});
	assign wrap_lo = np < 34'sh0;
	assign pos_new = wrap_up ? 32'(np - $signed({2'b00, cyc_len})) :
		wrap_lo ? 32'(np + $signed({2'b00, cyc_len})) : 32'(np);
	assign cbase   = 3'(cam - 4'h1);
	assign jb      = (jr >= {1'b0, res}) ? jr : jr + 13'h0001;
	assign dv_try  = {dv_rem[31:0], dv_quo[63]} - {1'b0, dv_den};

	// table entry for segment point j, rotated by the start index
	function automatic logic [11:0] ent(input logic [12:0] j);
		logic [12:0] e;
		e = j + {2'b00, sidx};
		ent = (e > {1'b0, res}) ? 12'(e - {1'b0, res}) : e[11:0];
	endfunction

	always_comb begin
		rd_val = 32'h0000_0000;
		case (ap_addr)
			cpe_pkg::A_CTRL:   rd_val = {24'h00_0000, cam_req, 3'h0, cam_engage_command};
			cpe_pkg::A_STROKE: rd_val = stroke_req;
			cpe_pkg::A_CYCLE:  rd_val = cyc_len;
			cpe_pkg::A_STD:    rd_val = std;
			cpe_pkg::A_STAT:   rd_val = {22'h00_0000, ctype, cam, 2'h0, pend,
				state != cpe_pkg::S_IDLE};
			cpe_pkg::A_FEED:   rd_val = feed_pos;
			cpe_pkg::A_POS:    rd_val = cyc_pos;
			cpe_pkg::A_ASTRK:  rd_val = stroke;
			default: begin
				if (ap_addr[7:5] == 3'h1) begin
					rd_val = {5'h00, prof[ap_addr[4:2]]};
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// evaluation sequencer, table reads and divider
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= cpe_pkg::S_IDLE;
			rret <= cpe_pkg::S_IDLE;
			dret <= cpe_pkg::S_IDLE;
			phase <= cpe_pkg::PH_POS;
			engage_q <= 1'b0;
			pend <= 1'b0;
			rd_ph <= 1'b0;
			wrap_dn <= 1'b0;
			cam <= 4'h0;
			ctype <= cpe_pkg::TYPE_RATIO;
			res <= 12'h001;
			sidx <= 11'h000;
			npt <= cpe_pkg::NPT_MIN;
			k <= 11'h001;
			stroke <= 32'sh0000_0000;
			std <= 32'sh0000_0000;
			cyc_pos <= 32'h0000_0000;
			q <= 33'sh0_0000_0000;
			rdat <= 32'h0000_0000;
			jr <= 13'h0000;
			rm <= 32'h0000_0000;
			ra <= 32'sh0000_0000;
			rb <= 32'sh0000_0000;
			xa <= 32'sh0000_0000;
			xb <= 32'sh0000_0000;
			ya <= 32'sh0000_0000;
			yb <= 32'sh0000_0000;
			ev <= 64'sh0;
			acc <= 64'sh0;
			dv_num <= 64'sh0;
			dv_quo <= 64'sh0;
			dv_den <= 32'h0000_0001;
			dv_rem <= 33'h0_0000_0000;
			dv_cnt <= 6'h00;
			dv_neg <= 1'b0;
			tbl_addr <= 15'h0000;
			step_ready <= 1'b1;
			feed_pos <= 32'h0000_0000;
			feed_valid <= 1'b0;
		end else begin
			engage_q <= cam_engage_command;
			feed_valid <= 1'b0;
			// engage edge wins over its own consumption
			if (cam_engage_command && !engage_q) begin
				pend <= 1'b1;
			end
			if (wr && ap_addr == cpe_pkg::A_STD) begin
				std <= hwdata;
			end
			case (state)
				cpe_pkg::S_IDLE: begin
					// an offered step is taken first, so a handshake never drops it
					if (pend && !(cam_engage_command && !engage_q) && !step_valid) begin
						pend <= 1'b0;
						if (cam_req <= cpe_pkg::CAM_MAX) begin
							cam <= cam_req;
							if (cam_req == 4'h0) begin
								ctype <= cpe_pkg::TYPE_RATIO;
								res <= 12'h001;
								sidx <= 11'h000;
								stroke <= stroke_req;
							end else begin
								ctype <= (preq[1:0] == cpe_pkg::TYPE_COORD) ?
									cpe_pkg::TYPE_COORD : cpe_pkg::TYPE_RATIO;
								res <= res_req;
								sidx <= ({1'b0, preq[cpe_pkg::F_START +: 11]} < res_req) ?
									preq[cpe_pkg::F_START +: 11] : 11'h000;
								npt <= npt_req;
								if (preq[1:0] != cpe_pkg::TYPE_COORD) begin
									stroke <= stroke_req;
								end
							end
							phase <= cpe_pkg::PH_POS;
							q <= $signed({1'b0, cyc_pos});
							step_ready <= 1'b0;
							state <= cpe_pkg::S_EVAL;
						end
					end else if (step_valid && step_ready) begin
						cyc_pos <= pos_new;
						wrap_dn <= wrap_lo;
						step_ready <= 1'b0;
						state <= cpe_pkg::S_EVAL;
						if (wrap_up || wrap_lo) begin
							phase <= cpe_pkg::PH_WL;
							q <= $signed({1'b0, cyc_len});
						end else begin
							phase <= cpe_pkg::PH_POS;
							q <= $signed({1'b0, pos_new});
						end
					end
				end
				cpe_pkg::S_EVAL: begin
					if (ctype == cpe_pkg::TYPE_COORD) begin
						k <= 11'h001;
						tbl_addr <= {cbase, 12'h002};
						rret <= cpe_pkg::S_C1;
						state <= cpe_pkg::S_RD;
					end else begin
						dv_num <= 64'(q) * 64'(res);
						dv_den <= cyc_len;
						dret <= cpe_pkg::S_R1;
						state <= cpe_pkg::S_DLD;
					end
				end
				// synchronous table: data one cycle after the address
				cpe_pkg::S_RD: begin
					rd_ph <= !rd_ph;
					if (rd_ph) begin
						rdat <= tbl_rdata;
						state <= rret;
					end
				end
				cpe_pkg::S_DLD: begin
					dv_neg <= dv_num[63];
					dv_quo <= dv_num[63] ? -dv_num : dv_num;
					dv_rem <= 33'h0_0000_0000;
					dv_cnt <= 6'h00;
					state <= cpe_pkg::S_DIV;
				end
				cpe_pkg::S_DIV: begin
					if (!dv_try[32]) begin
						dv_rem <= dv_try;
						dv_quo <= {dv_quo[62:0], 1'b1};
					end else begin
						dv_rem <= {dv_rem[31:0], dv_quo[63]};
						dv_quo <= {dv_quo[62:0], 1'b0};
					end
					dv_cnt <= dv_cnt + 6'h01;
					if (dv_cnt == 6'h3F) begin
						state <= cpe_pkg::S_DFIX;
					end
				end
				cpe_pkg::S_DFIX: begin
					if (dv_neg) begin
						dv_quo <= -dv_quo;
					end
					state <= dret;
				end
				cpe_pkg::S_R1: begin
					jr <= 13'(dv_quo);
					rm <= dv_rem[31:0];
					if (cam == 4'h0) begin
						ra <= (dv_quo == 64'sh0) ? 32'sh0 : cpe_pkg::RATIO_FULL;
						rb <= cpe_pkg::RATIO_FULL;
						state <= cpe_pkg::S_R4;
					end else begin
						tbl_addr <= {cbase, ent(13'(dv_quo))};
						rret <= cpe_pkg::S_R2;
						state <= cpe_pkg::S_RD;
					end
				end
				cpe_pkg::S_R2: begin
					ra <= rdat;
					tbl_addr <= {cbase, ent(jb)};
					rret <= cpe_pkg::S_R3;
					state <= cpe_pkg::S_RD;
				end
				cpe_pkg::S_R3: begin
					rb <= rdat;
					state <= cpe_pkg::S_R4;
				end
				cpe_pkg::S_R4: begin
					dv_num <= 64'(rb - ra) * $signed({32'h0000_0000, rm});
					dv_den <= cyc_len;
					dret <= cpe_pkg::S_R5;
					state <= cpe_pkg::S_DLD;
				end
				cpe_pkg::S_R5: begin
					dv_num <= 64'(ra + 32'(dv_quo)) * 64'(stroke);
					dv_den <= cpe_pkg::RATIO_FULL;
					dret <= cpe_pkg::S_R6;
					state <= cpe_pkg::S_DLD;
				end
				cpe_pkg::S_R6: begin
					ev <= dv_quo;
					state <= cpe_pkg::S_FIN;
				end
				// coordinate search never uses the start index
				cpe_pkg::S_C1: begin
					if ($signed(rdat) > q || k == npt - 11'h001) begin
						xb <= rdat;
						tbl_addr <= {cbase, k, 1'b1};
						rret <= cpe_pkg::S_C2;
					end else begin
						k <= k + 11'h001;
						tbl_addr <= {cbase, 11'(k + 11'h001), 1'b0};
						rret <= cpe_pkg::S_C1;
					end
					state <= cpe_pkg::S_RD;
				end
				cpe_pkg::S_C2: begin
					yb <= rdat;
					tbl_addr <= {cbase, 11'(k - 11'h001), 1'b0};
					rret <= cpe_pkg::S_C3;
					state <= cpe_pkg::S_RD;
				end
				cpe_pkg::S_C3: begin
					xa <= rdat;
					tbl_addr <= {cbase, 11'(k - 11'h001), 1'b1};
					rret <= cpe_pkg::S_C4;
					state <= cpe_pkg::S_RD;
				end
				cpe_pkg::S_C4: begin
					ya <= rdat;
					state <= cpe_pkg::S_C5;
				end
				cpe_pkg::S_C5: begin
					// outside the points this extends the end segment
					dv_num <= 64'(yb - ya) * 64'(q - xa);
					dv_den <= (xb == xa) ? 32'h0000_0001 : 32'(xb - xa);
					dret <= cpe_pkg::S_C6;
					state <= cpe_pkg::S_DLD;
				end
				cpe_pkg::S_C6: begin
					ev <= 64'(ya) + dv_quo;
					state <= cpe_pkg::S_FIN;
				end
				cpe_pkg::S_FIN: begin
					state <= cpe_pkg::S_EVAL;
					q <= $signed({1'b0, cyc_pos});
					phase <= cpe_pkg::PH_POS;
					case (phase)
						cpe_pkg::PH_WL: begin
							if (ctype == cpe_pkg::TYPE_COORD) begin
								acc <= ev;
								q <= 33'sh0_0000_0000;
								phase <= cpe_pkg::PH_W0;
							end else begin
								std <= wrap_dn ? std - 32'(ev) : std + 32'(ev);
							end
						end
						cpe_pkg::PH_W0: begin
							std <= wrap_dn ? std - 32'(acc - ev) :
								std + 32'(acc - ev);
						end
						default: begin
							feed_pos <= 32'(64'(std) + ev);
							feed_valid <= 1'b1;
							step_ready <= 1'b1;
							state <= cpe_pkg::S_IDLE;
						end
					endcase
				end
				default: begin
					state <= cpe_pkg::S_IDLE;
				end
			endcase
		end
	end
endmodule

// [test/cpe_table_model.sv]
// profile table memory standing behind the evaluator's table port
`timescale 1ns/1ps
module cpe_table_model (
	input  wire logic        clk,
	input  wire logic [14:0] addr,
	output logic      [31:0] rdata
);
	logic [31:0] mem [0:32767];

	// profile contents loaded by the bench
	task automatic put(input int a, input logic [31:0] d);
		mem[a] = d;
	endtask

	// one-cycle synchronous read, held until the address moves
	always @(posedge clk) begin
		rdata <= mem[addr];
	end
endmodule

// [test/cpe_monitor.sv]
// port-level checker for the cam profile evaluator
`timescale 1ns/1ps
module cpe_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        step_valid,
	input wire logic        step_ready,
	input wire logic [31:0] feed_pos,
	input wire logic        feed_valid
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------
	// bus
	// ------------------------------------------------------------
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write stalled");
	wait_cause_a: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans[1] && !hwrite))
		else $error("wait state without read");

	// ------------------------------------------------------------
	// position steps and feed
	// ------------------------------------------------------------
	logic [13:0] busy_cnt;

	// cycles spent with the step port closed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_cnt <= 14'h0000;
		end else if (step_ready) begin
			busy_cnt <= 14'h0000;
		end else begin
			busy_cnt <= busy_cnt + 14'h0001;
		end
	end

	step_taken_a: assert property (step_valid && step_ready |=> !step_ready)
		else $error("step accepted but still ready");
	busy_bound_a: assert property (busy_cnt < 14'h2EE0)
		else $error("evaluation did not finish");
	feed_pulse_a: assert property (feed_valid |=> !feed_valid)
		else $error("feed valid longer than one cycle");
	feed_ready_a: assert property (feed_valid |-> step_ready)
		else $error("feed valid while busy");
	feed_hold_a: assert property (!feed_valid |-> $stable(feed_pos))
		else $error("feed changed without valid");
endmodule

bind cpe_top cpe_monitor mon_u (
	.hclk       (hclk),
	.hresetn    (hresetn),
	.hsel       (hsel),
	.htrans     (htrans),
	.hwrite     (hwrite),
	.hready     (hready),
	.hreadyout  (hreadyout),
	.hresp      (hresp),
	.step_valid (step_valid),
	.step_ready (step_ready),
	.feed_pos   (feed_pos),
	.feed_valid (feed_valid)
);

// [test/cam_profile_evaluator_test.sv]
// self-checking bench for the cam profile evaluator
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cam_profile_evaluator_test;
	logic               hclk = 1'b0;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic        [31:0] haddr = 32'h0;
	logic        [1:0]  htrans = 2'h0;
	logic               hwrite = 1'b0;
	logic        [2:0]  hsize = 3'h2;
	logic        [31:0] hwdata = 32'h0;
	logic               hreadyout;
	logic        [31:0] hrdata;
	logic               hresp;
	logic               step_valid = 1'b0;
	logic signed [31:0] step_delta = 32'sh0;
	logic               step_ready;
	logic        [14:0] tbl_addr;
	logic        [31:0] tbl_rdata;
	logic        [31:0] feed_pos;
	logic               feed_valid;
	logic        [31:0] q;
	int                 failures = 0;
	int                 total_checks = 0;

	always #4 hclk = ~hclk;

	cpe_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.step_valid(step_valid), .step_delta(step_delta), .step_ready(step_ready),
		.tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .feed_pos(feed_pos),
		.feed_valid(feed_valid));
	cpe_table_model tbm_u (.clk(hclk), .addr(tbl_addr), .rdata(tbl_rdata));

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic engage(input logic [3:0] cam);
		wr(cpe_pkg::A_CTRL, {24'h0, cam, 4'h1});
		wr(cpe_pkg::A_CTRL, {24'h0, cam, 4'h0});
		do rd(cpe_pkg::A_STAT); while (q[1:0] !== 2'h0);
	endtask
	task automatic step(input logic [31:0] d);
		@(posedge hclk);
		step_valid <= 1'b1;
		step_delta <= d;
		do @(posedge hclk); while (step_ready !== 1'b1);
		step_valid <= 1'b0;
		do @(posedge hclk); while (feed_valid !== 1'b1);
	endtask
	task automatic do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		`CHK(feed_pos, 32'h0)
		rd(cpe_pkg::A_CYCLE);
		`CHK(q, 32'h0000_2710)
		rd(cpe_pkg::A_PROF + 8'h1C);
		`CHK(q, 32'h0002_0001)
		wr(8'h40, 32'h0000_5A5A);
		rd(8'h40);
		`CHK(q, 32'h0)
		engage(4'h9);
		`CHK(q[7:4], 4'h0)
	endtask
	task automatic t_linear;
		wr(cpe_pkg::A_CYCLE, 32'h0000_03E8);
		wr(cpe_pkg::A_STROKE, 32'h0000_07D0);
		engage(4'h0);
		step(32'h0000_00FA);
		`CHK(feed_pos, 32'h0000_01F4)
		rd(cpe_pkg::A_POS);
		`CHK(q, 32'h0000_00FA)
	endtask
	task automatic t_ratio;
		for (int e = 0; e <= 256; e++) begin
			tbm_u.put(e, 32'(e * 100));
			tbm_u.put(4096 + e, 32'(e * 100));
		end
		// reciprocating profile for cam four: last point back at zero
		for (int e = 0; e < 256; e++) begin
			tbm_u.put(12288 + e, 32'(e * 100));
		end
		tbm_u.put(12544, 32'h0);
		wr(cpe_pkg::A_CYCLE, 32'h0000_0A00);
		wr(cpe_pkg::A_STROKE, 32'h0001_86A0);
		wr(cpe_pkg::A_PROF, 32'h0002_0001);
		wr(cpe_pkg::A_PROF + 8'h04, 32'h0002_0041);
		engage(4'h1);
		`CHK(q[7:4], 4'h1)
		step(32'h0000_000F);
		`CHK(feed_pos, 32'h0000_0096)
		wr(cpe_pkg::A_STROKE, 32'h0000_C350);
		step(32'h0000_000A);
		`CHK(feed_pos, 32'h0000_00FA)
		engage(4'h2);
		rd(cpe_pkg::A_FEED);
		`CHK(q, 32'h0000_0145)
		wr(cpe_pkg::A_STROKE, 32'h0001_86A0);
		engage(4'h1);
		step(32'h0000_09E2);
		`CHK(feed_pos, 32'h0000_63CE)
		step(32'h0000_000A);
		`CHK(feed_pos, 32'h0000_6432)
		rd(cpe_pkg::A_STD);
		`CHK(q, 32'h0000_6400)
		rd(cpe_pkg::A_POS);
		`CHK(q, 32'h0000_0005)
		engage(4'h4);
		step(32'h0000_09FB);
		`CHK(feed_pos, 32'h0000_6400)
	endtask
	task automatic t_coord;
		tbm_u.put(8192, 32'h0000_0064);
		tbm_u.put(8193, 32'h0000_0000);
		tbm_u.put(8194, 32'h0000_00C8);
		tbm_u.put(8195, 32'h0000_03E8);
		tbm_u.put(8196, 32'h0000_012C);
		tbm_u.put(8197, 32'h0000_01F4);
		wr(cpe_pkg::A_CYCLE, 32'h0000_0A00);
		wr(cpe_pkg::A_PROF + 8'h08, 32'h0003_0052);
		wr(cpe_pkg::A_STROKE, 32'h0000_0007);
		engage(4'h3);
		`CHK(q[9:8], 2'h2)
		rd(cpe_pkg::A_FEED);
		`CHK(q, 32'hFFFF_FC18)
		rd(cpe_pkg::A_ASTRK);
		`CHK(q, 32'h0)
		step(32'h0000_0096);
		`CHK(feed_pos, 32'h0000_01F4)
		step(32'h0000_0974);
		`CHK(feed_pos, 32'hFFFF_D634)
		rd(cpe_pkg::A_STD);
		`CHK(q, 32'hFFFF_D9B8)
	endtask

	// ------------------------------------------------------------
	// sequence and verdict
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#400000;
		failures++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_values();
		t_linear();
		do_reset();
		t_ratio();
		do_reset();
		t_coord();
		give_verdict();
	end
endmodule
